// >>> rtl/esm_error_status.sv
`timescale 1ns/1ps
`default_nettype none
module esm_error_status
(
   // clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // error events, one-cycle pulses or levels
   input wire logic i_nan_evt,
   input wire logic i_irq_write_evt,
   input wire logic i_arith_evt,
   input wire logic i_addr_evt,
   input wire logic i_sanity_enable,
   input wire logic i_sanity_output,
   input wire logic i_sync_lost_evt,
   // host access
   input wire logic i_flags_rd,
   input wire logic i_masks_rd,
   input wire logic i_masks_wr,
   input wire logic [esm_pkg::MASK_W-1:0] i_wdata,
   output logic [esm_pkg::MASK_W-1:0] o_rdata,
   // outputs
   output logic o_host_notify_pin,
   output logic o_halt_req
);
   import esm_pkg::*;

   logic [FLAG_W-1:0] error_flags;
   logic [FLAG_W-1:0] next_error_flags;
   logic [MASK_W-1:0] error_masks;
   logic [MASK_W-1:0] next_error_masks;
   logic sanity_prev;
   logic [FLAG_W-1:0] events;
   logic [MASK_W-1:0] next_rdata;

   // event vector
   always_comb
   begin
      events = '0;
      events[NAN_BIT] = i_nan_evt;
      events[IRQW_BIT] = i_irq_write_evt;
      events[ARITH_BIT] = i_arith_evt;
      events[ADDR_BIT] = i_addr_evt;
      events[SANITY_BIT] = i_sanity_enable & sanity_prev & ~i_sanity_output;
      events[SYNC_BIT] = i_sync_lost_evt;
   end

   // next values: read clears, events set and win over the clear
   always_comb
   begin
      next_error_flags = error_flags;
      if (i_flags_rd)
         next_error_flags = '0;
      next_error_flags = next_error_flags | events;
      next_error_masks = error_masks;
      if (i_masks_wr)
         next_error_masks = i_wdata | MASK_RSVD;
      next_rdata = '0;
      if (i_flags_rd)
         next_rdata = {8'h00, error_flags};
      else if (i_masks_rd)
         next_rdata = error_masks | MASK_RSVD;
   end

   // registers
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         error_flags <= FLAGS_RESET;
         error_masks <= MASKS_RESET;
         sanity_prev <= 1'b0;
         o_rdata <= '0;
      end
      else if (i_ce)
      begin
         error_flags <= next_error_flags;
         error_masks <= next_error_masks;
         sanity_prev <= i_sanity_output;
         o_rdata <= next_rdata;
      end
   end

   // unmasked flags drive notification and halt
   assign o_host_notify_pin = |(error_flags & ~error_masks[7:0] & FLAG_USED);
   assign o_halt_req = |(error_flags & ~error_masks[MASK_W-1:HALT_OFS] & FLAG_USED);

   // the bit map is fixed: eight flags and a mask of two eight-bit halves
   if (FLAG_W != 8 || MASK_W != 2 * FLAG_W || HALT_OFS != FLAG_W)
   begin : g_bad_width
      $error("unsupported register widths");
   end

   // a host read hands back the old flags and keeps only same-cycle events
   chk_read_clears: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_flags_rd) |=> (error_flags == $past(events)))
      else $error("flags not cleared by read");

   // read data of a flags read is the flag byte, upper byte zero
   chk_flags_data: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_flags_rd) |=> (o_rdata == {8'h00, $past(error_flags)}))
      else $error("flags read data wrong");

   // reserved flag positions never set
   chk_flags_rsvd: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !error_flags[0] && !error_flags[3])
      else $error("reserved flag bit set");

   // flags only change on an event or a host read
   chk_flags_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && !i_flags_rd && events == '0) |=> $stable(error_flags))
      else $error("flags changed without cause");

   // read data returns to zero when no read is made
   chk_rdata_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && !i_flags_rd && !i_masks_rd) |=> (o_rdata == '0))
      else $error("read data not idle");

   // armed sanity output falling sets the sanity flag
   chk_sanity_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_sanity_enable && sanity_prev && !i_sanity_output) |=> error_flags[6])
      else $error("sanity loss missed");

   // sync loss sets the sync flag
   chk_sync_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_sync_lost_evt) |=> error_flags[7])
      else $error("sync loss missed");

   // a host write lands in the mask with reserved bits forced
   chk_mask_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_masks_wr) |=> (error_masks == ($past(i_wdata) | MASK_RSVD)))
      else $error("mask write lost");

   // the mask keeps its value between writes
   chk_mask_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && !i_masks_wr) |=> $stable(error_masks))
      else $error("mask changed without write");

   // a mask read returns the stored mask
   chk_mask_data: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_masks_rd && !i_flags_rd) |=> (o_rdata == ($past(error_masks) | MASK_RSVD)))
      else $error("mask read data wrong");

   // reserved mask bits read as one
   chk_rsvd_ones: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_masks_rd && !i_flags_rd) |=> ((o_rdata & MASK_RSVD) == MASK_RSVD))
      else $error("reserved mask bits not one");

   // reserved mask bits are also held as one
   chk_rsvd_stored: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (error_masks & MASK_RSVD) == MASK_RSVD)
      else $error("reserved mask bits stored as zero");

   // an unmasked overflow flag notifies the host
   chk_notify_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (error_flags[4] && !error_masks[4]) |-> o_host_notify_pin)
      else $error("notify not raised");

   // a fully masked notify half keeps the pin low
   chk_notify_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (error_masks[7:0] == 8'hff) |-> !o_host_notify_pin)
      else $error("masked flag notified");

   // an unmasked nan flag halts the processor
   chk_halt_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (error_flags[1] && !error_masks[9]) |-> o_halt_req)
      else $error("halt not raised");

   // a fully masked halt half keeps the request low
   chk_halt_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (error_masks[15:8] == 8'hff) |-> !o_halt_req)
      else $error("masked flag halted");

   // per-flag checks for every flag that owns a mask bit pair
   for (genvar b = 0; b < FLAG_W; b++)
   begin : g_gate_chk
      if (FLAG_USED[b] && !MASK_RSVD[b])
      begin : g_used
         chk_notify_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (error_flags[b] && !error_masks[b]) |-> o_host_notify_pin)
            else $error("unmasked flag did not notify");
         chk_halt_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (error_flags[b] && !error_masks[b + HALT_OFS]) |-> o_halt_req)
            else $error("unmasked flag did not halt");
      end
   end

   // all mask bits set keeps both outputs low
   chk_all_masked: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (error_masks == 16'hffff) |-> (!o_host_notify_pin && !o_halt_req))
      else $error("masked error leaked");

   // datapath events set their flags
   chk_nan_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_nan_evt) |=> error_flags[1])
      else $error("nan event missed");

   chk_irqw_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_irq_write_evt) |=> error_flags[2])
      else $error("irq write event missed");

   chk_arith_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_arith_evt) |=> error_flags[4])
      else $error("range event missed");

   chk_addr_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_ce && i_addr_evt) |=> error_flags[5])
      else $error("addressing event missed");

   // a low enable freezes every register
   chk_ce_freeze: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_ce |=> ($stable(error_flags) && $stable(error_masks) && $stable(o_rdata)))
      else $error("state moved with enable low");

   // main scenarios
   cov_notify: cover property (@(posedge i_sys_clk) o_host_notify_pin);
   cov_halt: cover property (@(posedge i_sys_clk) o_halt_req);
   cov_set_on_clear: cover property (@(posedge i_sys_clk) i_ce && i_flags_rd && i_arith_evt);
   cov_sanity_loss: cover property (@(posedge i_sys_clk) events[SANITY_BIT]);
   cov_write_read: cover property (@(posedge i_sys_clk) i_masks_wr ##1 i_masks_rd);
endmodule
`default_nettype wire

// >>> rtl/esm_pkg.sv
// Operation
// - 8-bit error status, host read only
// - host read clears error status
// - sanity armed and output falls sets bit6
// - sync loss sets bit 7
// - 16-bit mask, host readable and writable
// - reserved mask bits read as one
// - notify mask bits gate host notification
// - halt mask bits gate processor halt
// - halt mask bit n governs status n-8
// - reset sets every mask bit
package esm_pkg;
   localparam int FLAG_W = 8;
   localparam int MASK_W = 16;
   localparam int NAN_BIT = 1;
   localparam int IRQW_BIT = 2;
   localparam int ARITH_BIT = 4;
   localparam int ADDR_BIT = 5;
   localparam int SANITY_BIT = 6;
   localparam int SYNC_BIT = 7;
   localparam int HALT_OFS = 8;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] MASKS_RESET = 16'hffff;
   localparam logic [15:0] MASK_RSVD = 16'h0d0d;
   localparam logic [7:0] FLAG_USED = 8'hf6;
endpackage

// >>> tb/esm_host.sv
`timescale 1ns/1ps
`default_nettype none
module esm_host
(
   // host strobe port
   input wire logic i_sys_clk,
   output logic o_fr,
   output logic o_mr,
   output logic o_mw,
   output logic [15:0] o_wd
);
   initial {o_fr, o_mr, o_mw, o_wd} = '0;
   // one access launched just after an edge
   task automatic go(input logic f, m, w, input logic [15:0] d);
      @(posedge i_sys_clk);
      {o_fr, o_mr, o_mw, o_wd} <= {f, m, w, d};
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import esm_pkg::*;
   logic clk = 0, rst = 1, en = 0, so = 0, ce = 1, n, fr, mr, mw, nt, hl;
   logic [7:0] ev = 0, f, e;
   logic [15:0] rd, m, wd;
   logic [31:0] s = 32'h98ff752c;
   int errors = 0, num_checks = 0, cyc = 0;
   always #25 clk = ~clk;
   esm_host H (.i_sys_clk(clk), .o_fr(fr), .o_mr(mr), .o_mw(mw), .o_wd(wd));
   esm_error_status DUT (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_nan_evt(ev[1]),
      .i_irq_write_evt(ev[2]), .i_arith_evt(ev[4]), .i_addr_evt(ev[5]), .i_sanity_enable(en),
      .i_sanity_output(so), .i_sync_lost_evt(ev[7]), .i_flags_rd(fr), .i_masks_rd(mr),
      .i_masks_wr(mw), .i_wdata(wd), .o_rdata(rd), .o_host_notify_pin(nt), .o_halt_req(hl));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   // expected {halt, notify} from flags and stored mask
   function automatic logic [1:0] gate(input logic [7:0] fl, input logic [15:0] mk);
      return {|(fl & ~mk[15:8]), |(fl & ~mk[7:0])};
   endfunction
   task automatic cmp(input string nm, input logic [15:0] x, input logic [15:0] g);
      num_checks++;
      if (g !== x)
      begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, x, g);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         end_sim();
      end
   end
   // write mask, raise events, then read flags and mask
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 0;
      H.go(0, 1, 0, 0);
      H.go(0, 0, 0, 0);
      #1 cmp("mask_rst", MASKS_RESET, rd);
      // a write with the enable low must be ignored
      H.go(0, 0, 1, 16'h0000);
      ce <= 0;
      H.go(0, 1, 0, 0);
      ce <= 1;
      H.go(0, 0, 0, 0);
      #1 cmp("ce_hold", MASKS_RESET, rd);
      for (int i = 0; i < 200; i++)
      begin
         s = xs(s);
         m = i == 0 ? 16'h0000 : i == 1 ? 16'hffff : s[15:0];
         e = i < 2 ? 8'hff : s[23:16];
         n = i < 2 || s[24];
         f = (e & 8'hb6) | {1'b0, n, 6'h00};
         H.go(0, 0, 1, m);
         so <= 1;
         H.go(0, 0, 0, 0);
         ev <= e;
         en <= n;
         so <= 0;
         H.go(1, 0, 0, 0);
         ev <= 0;
         #1 cmp("gates", gate(f, m | MASK_RSVD), {hl, nt});
         H.go(0, 1, 0, 0);
         #1 cmp("flags", f, rd);
         H.go(0, 0, 0, 0);
         #1 cmp("cleared", 0, {hl, nt});
         cmp("masks", m | MASK_RSVD, rd);
      end
      end_sim();
   end
endmodule
`default_nettype wire
